// File: src/rdoc_link_if.sv
`timescale 1ns/1ns
// Purpose: Carries data window accesses to the link configuration store.
// Assumes: One clock; strobes last one cycle.
// Notes:   Read data is combinational from the store.
interface rdoc_link_if;
  logic [19:0] addr;
  logic [7:0]  wdata;
  logic        wr_stb;
  logic        clr_stb;
  logic [7:0]  rdata;
  modport master (output addr, output wdata, output wr_stb, output clr_stb, input rdata);
  modport slave  (input addr, input wdata, input wr_stb, input clr_stb, output rdata);
endinterface

// File: src/rdoc_link_store.sv
`timescale 1ns/1ns
// Purpose: Small link configuration store behind the data window.
// Assumes: Only a window of addresses from the base is implemented.
// Notes:   Other addresses read zero and ignore writes.
module rdoc_link_store
  import rdoc_pkg::*;
#(
  parameter int DEPTH = RDOC_LINK_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  rdoc_link_if.slave lnk
);
  logic [7:0] mem [DEPTH];
  logic       hit;
  logic [3:0] idx;

  // Decode the pointer into the implemented window.
  assign hit       = (lnk.addr >= RDOC_LINK_BASE) && (lnk.addr < RDOC_LINK_BASE + 20'(DEPTH));
  assign idx       = 4'(lnk.addr - RDOC_LINK_BASE);
  assign lnk.rdata = hit ? mem[idx] : 8'h00;

  // The clear strobe wipes only the upper part of the window.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= 8'h00;
    end else if (lnk.clr_stb) begin
      for (int i = RDOC_LCLR_FIRST; i < DEPTH; i++) mem[i] <= 8'h00;
    end else if (lnk.wr_stb && hit) begin
      mem[idx] <= lnk.wdata;
    end
  end
endmodule

// File: src/rdoc_pkg.sv
// Purpose: Shared constants for the re-driver output configuration registers.
// Assumes: Byte-wide registers reached over the two-wire serial port.
// Notes:   Offsets are sub-addresses; field positions give the low bit.
package rdoc_pkg;
  localparam logic [7:0]  RDOC_OFS_COND     = 8'h15;
  localparam logic [7:0]  RDOC_OFS_HPD      = 8'h17;
  localparam logic [7:0]  RDOC_OFS_TMDSPRE  = 8'h18;
  localparam logic [7:0]  RDOC_OFS_FACT0    = 8'h19;
  localparam logic [7:0]  RDOC_OFS_FACT1    = 8'h1A;
  localparam logic [7:0]  RDOC_OFS_RST      = 8'h1B;
  localparam logic [7:0]  RDOC_OFS_AHI      = 8'h1C;
  localparam logic [7:0]  RDOC_OFS_AMID     = 8'h1D;
  localparam logic [7:0]  RDOC_OFS_ALO      = 8'h1E;
  localparam logic [7:0]  RDOC_OFS_DATA     = 8'h1F;
  localparam int          RDOC_BOOST_LSB    = 3;
  localparam int          RDOC_SWING_BIT    = 2;
  localparam int          RDOC_PRE_LSB      = 0;
  localparam int          RDOC_HPDTEST_BIT  = 3;
  localparam int          RDOC_ADPOL_BIT    = 1;
  localparam int          RDOC_ADFORCE_BIT  = 0;
  localparam int          RDOC_TPRE_LSB     = 2;
  localparam int          RDOC_SOFTRST_BIT  = 7;
  localparam int          RDOC_LCLR_BIT     = 6;
  localparam logic [4:0]  RDOC_COND_RST     = 5'h08;
  localparam logic [3:0]  RDOC_HPD_RST      = 4'h0;
  localparam logic [1:0]  RDOC_TPRE_RST     = 2'h0;
  localparam logic [7:0]  RDOC_FACT_RST     = 8'h00;
  localparam logic [19:0] RDOC_PTR_RST      = 20'h00000;
  localparam logic [6:0]  RDOC_DEV_ADDR     = 7'h2C; // Arbitrary value.
  localparam logic [19:0] RDOC_LINK_BASE    = 20'h00100;
  localparam int          RDOC_LINK_DEPTH   = 16;
  localparam int          RDOC_LCLR_FIRST   = 3;
  localparam int          RDOC_SYNC_W       = 6;
endpackage

// File: src/rdoc_regs_top.sv
`timescale 1ns/1ns
// Purpose: Output conditioning, hot-plug test and link pointer registers with serial slave.
// Assumes: Slow two-wire bus against the 20 MHz clock; pins other than dp_preemph_en_in pass a three-stage sync.
// Notes:   The data line is open drain; sda_oe_out high pulls it low.
module rdoc_regs_top
  import rdoc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = RDOC_DEV_ADDR
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        dp_sink_sel_in,
  input  wire logic        sink_adapter_detect_in,
  input  wire logic        dp_sink_hotplug_in,
  input  wire logic        tmds_sink_hotplug_in,
  input  wire logic        dp_preemph_en_in,
  output logic [1:0]       output_boost_trim_out,
  output logic             boost_on_preemph_out,
  output logic             boost_on_swing_out,
  output logic             tmds_mode_out,
  output logic             dp_sink_tmds_swing_sel_out,
  output logic [1:0]       dp_sink_tmds_preemph_sel_out,
  output logic [1:0]       tmds_port_preemph_out,
  output logic             hotplug_compliance_test_out,
  output logic             dp_sink_hotplug_eff_out,
  output logic             tmds_sink_hotplug_eff_out,
  output logic             source_hotplug_out,
  output logic             source_adapter_detect_out,
  output logic [19:0]      link_cfg_addr_out
);
  typedef enum {
    RDOC_IDLE, RDOC_DEVADR, RDOC_ACK_DEV, RDOC_SUBADR, RDOC_ACK_SUB,
    RDOC_WRDAT, RDOC_ACK_WR, RDOC_RDDAT, RDOC_ACK_RD
  } rdoc_state_t;

  rdoc_link_if lnk ();

  logic [RDOC_SYNC_W-1:0] pins;
  logic        scl;
  logic        sda;
  logic        scl_q;
  logic        sda_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  rdoc_state_t state;
  logic [7:0]  shreg;
  logic [3:0]  bitcnt;
  logic        rw;
  logic [7:0]  ptr;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rdata;
  logic [4:0]  cond;
  logic [3:0]  hpd;
  logic [1:0]  tpre;
  logic [7:0]  fact0;
  logic [7:0]  fact1;
  logic [19:0] lptr;
  logic        soft_rst;
  logic        link_clr;
  logic        ad_s;
  logic        dpsel_s;

  // Bus lines and status pins except dp_preemph_en_in pass the synchroniser; idle bus lines rest high.
  rdoc_sync #(
    .W       (RDOC_SYNC_W),
    .RST_VAL (8'h03)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .d_in     ({dp_sink_sel_in, tmds_sink_hotplug_in, dp_sink_hotplug_in,
                sink_adapter_detect_in, sda_in, scl_in}),
    .q_out    (pins)
  );

  assign scl     = pins[0];
  assign sda     = pins[1];
  assign ad_s    = pins[2];
  assign dpsel_s = pins[5];

  // Edge and condition detection on the filtered bus lines.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_c  = scl & scl_q & sda_q & ~sda;
  assign stop_c   = scl & scl_q & ~sda_q & sda;
  assign sda_out  = 1'b0;

  // Serial slave sequencer. The data line only changes after a clock fall,
  // which leaves over four cycles of hold, ample for standard-mode hosts.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || stop_c) begin
      state      <= RDOC_IDLE;
      shreg      <= 8'h00;
      bitcnt     <= 4'h0;
      rw         <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (start_c) begin
      state      <= RDOC_DEVADR;
      bitcnt     <= 4'h0;
      sda_oe_out <= 1'b0;
    end else begin
      unique case (state)
        RDOC_IDLE: begin
        end
        RDOC_DEVADR, RDOC_SUBADR, RDOC_WRDAT: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            sda_oe_out <= 1'b1;
            if (state == RDOC_SUBADR) begin
              state <= RDOC_ACK_SUB;
            end else if (state == RDOC_WRDAT) begin
              state <= RDOC_ACK_WR;
            end else if (shreg[7:1] == DEV_ADDR) begin
              state <= RDOC_ACK_DEV;
              rw    <= shreg[0];
            end else begin
              state      <= RDOC_IDLE;
              sda_oe_out <= 1'b0;
            end
          end
        end
        RDOC_ACK_DEV: begin
          if (scl_fall) begin
            bitcnt <= 4'h0;
            if (rw) begin
              state      <= RDOC_RDDAT;
              shreg      <= rdata;
              sda_oe_out <= ~rdata[7];
            end else begin
              state      <= RDOC_SUBADR;
              sda_oe_out <= 1'b0;
            end
          end
        end
        RDOC_ACK_SUB, RDOC_ACK_WR: begin
          if (scl_fall) begin
            state      <= RDOC_WRDAT;
            bitcnt     <= 4'h0;
            sda_oe_out <= 1'b0;
          end
        end
        RDOC_RDDAT: begin
          if (scl_fall) begin
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == 4'h7) begin
              state      <= RDOC_ACK_RD;
              sda_oe_out <= 1'b0;
            end else begin
              shreg      <= {shreg[6:0], 1'b0};
              sda_oe_out <= ~shreg[6];
            end
          end
        end
        RDOC_ACK_RD: begin
          // A refusal from the host ends the read; an acknowledge loads the next byte.
          if (scl_rise && sda) begin
            state <= RDOC_IDLE;
          end else if (scl_fall) begin
            state      <= RDOC_RDDAT;
            bitcnt     <= 4'h0;
            shreg      <= rdata;
            sda_oe_out <= ~rdata[7];
          end
        end
      endcase
    end
  end

  // Sub-address pointer: loaded by the first written byte, advanced after each data byte.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ptr <= 8'h00;
    end else if (state == RDOC_SUBADR && scl_fall && bitcnt == 4'h8) begin
      ptr <= shreg;
    end else if (scl_fall && (state == RDOC_ACK_WR || (state == RDOC_RDDAT && bitcnt == 4'h7))) begin
      ptr <= ptr + 8'h01;
    end
  end

  // One-cycle write strobe once a data byte is complete.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_stb  <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= state == RDOC_WRDAT && scl_fall && bitcnt == 4'h8 && !stop_c && !start_c;
      if (state == RDOC_WRDAT && scl_fall && bitcnt == 4'h8) begin
        wr_addr <= ptr;
        wr_data <= shreg;
      end
    end
  end

  // Configuration registers. The soft reset restores them all one cycle after its write.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || soft_rst) begin
      cond  <= RDOC_COND_RST;
      hpd   <= RDOC_HPD_RST;
      tpre  <= RDOC_TPRE_RST;
      fact0 <= RDOC_FACT_RST;
      fact1 <= RDOC_FACT_RST;
      lptr  <= RDOC_PTR_RST;
    end else if (wr_stb) begin
      unique case (wr_addr)
        RDOC_OFS_COND:    cond       <= wr_data[4:0];
        RDOC_OFS_HPD:     hpd        <= wr_data[3:0];
        RDOC_OFS_TMDSPRE: tpre       <= wr_data[RDOC_TPRE_LSB +: 2];
        RDOC_OFS_FACT0:   fact0      <= wr_data;
        RDOC_OFS_FACT1:   fact1      <= wr_data;
        RDOC_OFS_AHI:     lptr[19:16] <= wr_data[3:0];
        RDOC_OFS_AMID:    lptr[15:8]  <= wr_data;
        RDOC_OFS_ALO:     lptr[7:0]   <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // Self-clearing reset strobes; nothing stores them beyond the one cycle.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      soft_rst <= 1'b0;
      link_clr <= 1'b0;
    end else begin
      soft_rst <= wr_stb && wr_addr == RDOC_OFS_RST && wr_data[RDOC_SOFTRST_BIT];
      link_clr <= wr_stb && wr_addr == RDOC_OFS_RST && wr_data[RDOC_LCLR_BIT];
    end
  end

  // Data window access to the link store through the 20-bit pointer.
  assign lnk.addr    = lptr;
  assign lnk.wdata   = wr_data;
  assign lnk.wr_stb  = wr_stb && wr_addr == RDOC_OFS_DATA;
  assign lnk.clr_stb = link_clr;

  rdoc_link_store #(
    .DEPTH (RDOC_LINK_DEPTH)
  ) u_store (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .lnk      (lnk)
  );

  // Read mux. Undefined bits except hot-plug bit 2, the reset register and unmapped offsets read zero.
  always_comb begin
    rdata = 8'h00;
    unique case (ptr)
      RDOC_OFS_COND:    rdata = {3'h0, cond};
      RDOC_OFS_HPD:     rdata = {4'h0, hpd};
      RDOC_OFS_TMDSPRE: rdata = {4'h0, tpre, 2'h0};
      RDOC_OFS_FACT0:   rdata = fact0;
      RDOC_OFS_FACT1:   rdata = fact1;
      RDOC_OFS_AHI:     rdata = {4'h0, lptr[19:16]};
      RDOC_OFS_AMID:    rdata = lptr[15:8];
      RDOC_OFS_ALO:     rdata = lptr[7:0];
      RDOC_OFS_DATA:    rdata = lnk.rdata;
      default:          rdata = 8'h00;
    endcase
  end

  // Registered outputs to the analog drivers and hot-plug pins. Boost covers both the
  // DP and the TMDS use of the DP sink, so it needs the sink selection and dp_preemph_en_in, not the adapter detect.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      output_boost_trim_out        <= RDOC_COND_RST[4:3];
      boost_on_preemph_out         <= 1'b0;
      boost_on_swing_out           <= 1'b0;
      tmds_mode_out                <= 1'b0;
      dp_sink_tmds_swing_sel_out   <= 1'b0;
      dp_sink_tmds_preemph_sel_out <= 2'h0;
      tmds_port_preemph_out        <= 2'h0;
      hotplug_compliance_test_out  <= 1'b0;
      dp_sink_hotplug_eff_out      <= 1'b0;
      tmds_sink_hotplug_eff_out    <= 1'b0;
      source_hotplug_out           <= 1'b0;
      source_adapter_detect_out    <= 1'b0;
      link_cfg_addr_out            <= RDOC_PTR_RST;
    end else begin
      output_boost_trim_out        <= cond[RDOC_BOOST_LSB +: 2];
      boost_on_preemph_out         <= dpsel_s && dp_preemph_en_in;
      boost_on_swing_out           <= dpsel_s && !dp_preemph_en_in;
      tmds_mode_out                <= dpsel_s && ad_s;
      dp_sink_tmds_swing_sel_out   <= dpsel_s && ad_s && cond[RDOC_SWING_BIT];
      dp_sink_tmds_preemph_sel_out <= (dpsel_s && ad_s) ? cond[RDOC_PRE_LSB +: 2] : 2'h0;
      tmds_port_preemph_out        <= tpre;
      hotplug_compliance_test_out  <= hpd[RDOC_HPDTEST_BIT];
      if (hpd[RDOC_HPDTEST_BIT]) begin
        dp_sink_hotplug_eff_out   <= 1'b1;
        tmds_sink_hotplug_eff_out <= 1'b0;
        source_hotplug_out        <= 1'b1;
      end else begin
        dp_sink_hotplug_eff_out   <= pins[3];
        tmds_sink_hotplug_eff_out <= pins[4];
        source_hotplug_out        <= dpsel_s ? pins[3] : pins[4];
      end
      if (dpsel_s) begin
        source_adapter_detect_out <= (hpd[RDOC_ADFORCE_BIT] | ad_s) ^ hpd[RDOC_ADPOL_BIT];
      end else begin
        source_adapter_detect_out <= 1'b0;
      end
      link_cfg_addr_out <= lptr;
    end
  end
endmodule

// File: src/rdoc_sync.sv
`timescale 1ns/1ns
// Purpose: Three-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clk_in.
// Notes:   A change counts once stages two and three agree.
module rdoc_sync #(
  parameter int         W       = 1,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Stage one feeds only stage two, so a metastable value never spreads.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1    <= RST_VAL[W-1:0];
      s2    <= RST_VAL[W-1:0];
      s3    <= RST_VAL[W-1:0];
      q_out <= RST_VAL[W-1:0];
    end else begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          q_out[i] <= s3[i];
        end
      end
    end
  end
endmodule

// File: tb/rdoc_host_model.sv
// Purpose: Two-wire serial host that reaches the configuration registers.
// Assumes: The data line has a pull-up; the bench forms the wired level.
// Notes:   A quarter bit is Q clocks so the slave's ack delay fits with margin.
`timescale 1ns/1ns
module rdoc_host_model #(
  parameter int         Q   = 6,
  parameter logic [6:0] DEV = 7'h2C
) (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_pull_out
);
  // Idle bus: clock high and data released.
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  task automatic qw();
    repeat (Q) @(negedge clk_in);
  endtask
  // Data is released before the clock rises, so this also serves as a repeated start.
  task automatic start();
    qw();
    sda_pull_out = 1'b0;
    qw();
    scl_out = 1'b1;
    qw();
    sda_pull_out = 1'b1;
    qw();
    scl_out = 1'b0;
  endtask
  task automatic stop();
    qw();
    sda_pull_out = 1'b1;
    qw();
    scl_out = 1'b1;
    qw();
    sda_pull_out = 1'b0;
    qw();
  endtask
  // Data changes only while the clock is low and is sampled mid-high.
  task automatic xbit(input logic b, output logic r);
    qw();
    sda_pull_out = ~b;
    qw();
    scl_out = 1'b1;
    qw();
    r = sda_in;
    qw();
    scl_out = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
    logic t;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], t);
      r[i] = t;
    end
    xbit(last, t);
    ack = ~t;
  endtask
  // Single byte write; the factory test pair is never addressed.
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    logic       a2;
    ok = 1'b0;
    if (ofs == 8'h19 || ofs == 8'h1A) begin
      return;
    end
    start();
    xbyte({DEV, 1'b0}, 1'b1, r, a0);
    xbyte(ofs, 1'b1, r, a1);
    xbyte(d, 1'b1, r, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  // Single byte read ending with a host not-acknowledge.
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       n;
    start();
    xbyte({DEV, 1'b0}, 1'b1, r, a0);
    xbyte(ofs, 1'b1, r, a1);
    start();
    xbyte({DEV, 1'b1}, 1'b1, r, a2);
    xbyte(8'hFF, 1'b1, d, n);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic probe(input logic [7:0] a, output logic ack);
    logic [7:0] r;
    start();
    xbyte(a, 1'b1, r, ack);
    stop();
  endtask
endmodule

// File: tb/rdoc_regs_monitor.sv
// Purpose: Port checker for the output configuration registers.
// Assumes: A pin held for eight clocks has passed the synchroniser and output flop.
// Notes:   Bound to every instance of the register top.
`timescale 1ns/1ns
module rdoc_regs_monitor (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        sda_oe_out,
  input wire logic        dp_sink_sel_in,
  input wire logic        sink_adapter_detect_in,
  input wire logic        dp_sink_hotplug_in,
  input wire logic        dp_preemph_en_in,
  input wire logic [1:0]  output_boost_trim_out,
  input wire logic        boost_on_preemph_out,
  input wire logic        boost_on_swing_out,
  input wire logic        tmds_mode_out,
  input wire logic        dp_sink_tmds_swing_sel_out,
  input wire logic [1:0]  dp_sink_tmds_preemph_sel_out,
  input wire logic [1:0]  tmds_port_preemph_out,
  input wire logic        hotplug_compliance_test_out,
  input wire logic        dp_sink_hotplug_eff_out,
  input wire logic        tmds_sink_hotplug_eff_out,
  input wire logic        source_hotplug_out,
  input wire logic        source_adapter_detect_out,
  input wire logic [19:0] link_cfg_addr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Settled pin conditions; eight clocks cover sync, filter and output stages.
  sequence s_dp_tmds;
    (dp_sink_sel_in && sink_adapter_detect_in)[*8];
  endsequence
  sequence s_dp_pre;
    (dp_sink_sel_in && dp_preemph_en_in)[*8];
  endsequence
  sequence s_dp_swg;
    (dp_sink_sel_in && !dp_preemph_en_in)[*8];
  endsequence
  sequence s_no_dp;
    (!dp_sink_sel_in)[*8];
  endsequence
  sequence s_hpd_live;
    (!hotplug_compliance_test_out && dp_sink_sel_in && dp_sink_hotplug_in)[*8];
  endsequence
  chk_boost_reset: assert property ($rose(rst_n_in) |-> output_boost_trim_out == 2'h1)
    else $error("boost field not nominal after reset");
  chk_boost_preemph: assert property (s_dp_pre |-> boost_on_preemph_out && !boost_on_swing_out)
    else $error("boost not steering pre-emphasis");
  chk_boost_swing: assert property (s_dp_swg |-> boost_on_swing_out && !boost_on_preemph_out)
    else $error("boost not steering swing");
  chk_tmds_mode: assert property (s_dp_tmds |-> tmds_mode_out)
    else $error("tmds mode missing with adapter present");
  chk_tmds_gate: assert property (!tmds_mode_out && !$past(tmds_mode_out) |->
    !dp_sink_tmds_swing_sel_out && dp_sink_tmds_preemph_sel_out == 2'h0)
    else $error("tmds swing or pre-emphasis outside tmds mode");
  chk_hpd_force: assert property (hotplug_compliance_test_out && $past(hotplug_compliance_test_out) |->
    source_hotplug_out && dp_sink_hotplug_eff_out && !tmds_sink_hotplug_eff_out)
    else $error("compliance test not forcing hot-plug levels");
  chk_hpd_follow: assert property (s_hpd_live |-> source_hotplug_out && dp_sink_hotplug_eff_out)
    else $error("hot-plug not following the sink pin");
  chk_no_dp_sel: assert property (s_no_dp |-> !source_adapter_detect_out && !tmds_mode_out
    && !boost_on_preemph_out && !boost_on_swing_out)
    else $error("dp sink outputs active while deselected");
  chk_cfg_on_ack: assert property ($changed(link_cfg_addr_out) || $changed(output_boost_trim_out)
    || $changed(tmds_port_preemph_out) |-> sda_oe_out)
    else $error("configuration changed outside an acknowledged byte");
endmodule
bind rdoc_regs_top rdoc_regs_monitor u_mon (.clk_in, .rst_n_in, .sda_oe_out, .dp_sink_sel_in,
  .sink_adapter_detect_in, .dp_sink_hotplug_in, .dp_preemph_en_in, .output_boost_trim_out,
  .boost_on_preemph_out, .boost_on_swing_out, .tmds_mode_out, .dp_sink_tmds_swing_sel_out,
  .dp_sink_tmds_preemph_sel_out, .tmds_port_preemph_out, .hotplug_compliance_test_out,
  .dp_sink_hotplug_eff_out, .tmds_sink_hotplug_eff_out, .source_hotplug_out,
  .source_adapter_detect_out, .link_cfg_addr_out);

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the output configuration registers.
// Assumes: The host model owns the bus pins; all pins change on falling edges.
// Notes:   A read checks the frame acknowledges together with the data.
`timescale 1ns/1ns
module tb_top;
  logic        clk_in;
  logic        rst_n_in;
  logic        scl, pull, oe, sda, ack;
  logic        sel, adp, dhp, thp, pen;
  logic [1:0]  trim, vpre, tpre;
  logic        bpre, bswg, tmds, swg, hct, dpe, tme, shp, cad;
  logic [19:0] addr;
  int          num_errors = 0;
  int          comparisons = 0;
  // Wired data line: high on its pull-up unless a party pulls it low.
  assign sda = ~(pull | oe);
  // Free running 20 MHz clock.
  initial clk_in = 1'b0;
  always #25 clk_in = ~clk_in;
  rdoc_regs_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe_out(oe), .dp_sink_sel_in(sel), .sink_adapter_detect_in(adp), .dp_sink_hotplug_in(dhp),
    .tmds_sink_hotplug_in(thp), .dp_preemph_en_in(pen), .output_boost_trim_out(trim),
    .boost_on_preemph_out(bpre), .boost_on_swing_out(bswg), .tmds_mode_out(tmds),
    .dp_sink_tmds_swing_sel_out(swg), .dp_sink_tmds_preemph_sel_out(vpre), .tmds_port_preemph_out(tpre),
    .hotplug_compliance_test_out(hct), .dp_sink_hotplug_eff_out(dpe), .tmds_sink_hotplug_eff_out(tme),
    .source_hotplug_out(shp), .source_adapter_detect_out(cad), .link_cfg_addr_out(addr));
  rdoc_host_model host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] ofs, input logic [7:0] d);
    logic ok;
    host.wr(ofs, d, ok);
    chk({19'h0, ok}, 20'h1);
  endtask
  task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] v;
    logic       ok;
    host.rd(ofs, v, ok);
    chk({11'h0, ok, v}, {11'h0, 1'b1, exp});
  endtask
  // Pins: select, adapter, dp hot-plug, tmds hot-plug, pre-emphasis enable; then let them settle.
  task automatic pins(input logic [4:0] p);
    {sel, adp, dhp, thp, pen} = p;
    repeat (8) @(negedge clk_in);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // A hang is cut short and counted as a failure.
  initial begin
    repeat (100000) @(posedge clk_in);
    num_errors++;
    wrap_up();
  end
  // Main sequence of register tests.
  initial begin
    rst_n_in = 1'b0;
    {sel, adp, dhp, thp, pen} = 5'h00;
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (8) @(negedge clk_in);
    chk(trim, 2'h1);
    for (int i = 0; i < 11; i++) begin
      rchk(8'h15 + 8'(i), (i == 0) ? 8'h08 : 8'h00);
    end
    $display("reset values done");
    pins(5'h18);
    chk(tmds, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wreg(8'h15, {3'h0, i[1:0], i[0], i[1:0]});
      chk(trim, i[1:0]);
      chk(swg, i[0]);
      chk(vpre, i[1:0]);
      rchk(8'h15, {3'h0, i[1:0], i[0], i[1:0]});
    end
    pins(5'h10);
    chk({tmds, swg, vpre}, 4'h0);
    chk(bswg, 1'b1);
    pins(5'h11);
    chk(bpre, 1'b1);
    $display("boost and tmds done");
    pins(5'h12);
    wreg(8'h17, 8'h08);
    chk({hct, dpe, tme, shp}, 4'hD);
    wreg(8'h17, 8'h00);
    chk({hct, dpe, tme, shp}, 4'h2);
    // Live sink hot-plug must reach the source pin once the test bit is off.
    pins(5'h14);
    chk({hct, dpe, tme, shp}, 4'h5);
    pins(5'h02);
    chk({hct, dpe, tme, shp}, 4'h3);
    for (int i = 0; i < 8; i++) begin
      pins({1'b1, i[0], 3'h0});
      wreg(8'h17, {6'h0, i[1], i[2]});
      chk(cad, (i[2] | i[0]) ^ i[1]);
    end
    pins(5'h00);
    chk(cad, 1'b0);
    $display("hot-plug and adapter done");
    for (int i = 0; i < 4; i++) begin
      wreg(8'h18, {4'h0, i[1:0], 2'h0});
      chk(tpre, i[1:0]);
      rchk(8'h18, {4'h0, i[1:0], 2'h0});
    end
    $display("tmds port done");
    wreg(8'h1C, 8'hF1);
    wreg(8'h1D, 8'h23);
    wreg(8'h1E, 8'h45);
    chk(addr, 20'h12345);
    rchk(8'h1C, 8'h01);
    wreg(8'h1C, 8'h00);
    wreg(8'h1D, 8'h01);
    wreg(8'h1E, 8'h02);
    wreg(8'h1F, 8'h5A);
    wreg(8'h1E, 8'h03);
    wreg(8'h1F, 8'hA5);
    rchk(8'h1F, 8'hA5);
    wreg(8'h1B, 8'h40);
    rchk(8'h1F, 8'h00);
    rchk(8'h1B, 8'h00);
    wreg(8'h1E, 8'h02);
    rchk(8'h1F, 8'h5A);
    $display("link window done");
    wreg(8'h15, 8'h00);
    wreg(8'h1B, 8'h80);
    chk(trim, 2'h1);
    chk(tpre, 2'h0);
    chk(addr, 20'h0);
    rchk(8'h15, 8'h08);
    rchk(8'h1E, 8'h00);
    wreg(8'h15, 8'h10);
    chk(trim, 2'h2);
    host.probe(8'h5A, ack);
    chk(ack, 1'b0);
    $display("soft reset and address done");
    wrap_up();
  end
endmodule
